// ### bench/fifo_peer.sv
// Producer and consumer standing at the FIFO pins, commanded by the bench.
// Assumes commands change just after a rising edge of i_clk.
`timescale 1ns/1ps
module fifo_peer (
    input  wire       i_clk,
    input  wire       i_go_push,
    input  wire       i_go_pop,
    input  wire       i_one_en,
    input  wire [8:0] i_word,
    output wire       o_push_a_n,
    output wire       o_pop_a_n,
    output wire       o_pop_b_n,
    output wire [8:0] o_data
);
    reg [8:0] last_q = 9'h000;
    always @(posedge i_clk)
        if (i_go_push) last_q <= i_word;
    // Bench commands pushes in s_regs before its first clear
    assign o_push_a_n = !i_go_push;
    // Idle data shows the inverse of the last word, never a stale copy
    assign o_data = i_go_push ? i_word : ~last_q;
    assign o_pop_a_n = !i_go_pop;
    assign o_pop_b_n = !(i_go_pop && !i_one_en);
endmodule // fifo_peer

// ### bench/fifo_rp_sva.sv
// Checker for the FIFO read port: flags, pop data and output enable.
// Assumes the single clock i_clk and the async active-low reset i_rst_n.
`timescale 1ns/1ps
module fifo_rp_sva (
    input wire       i_clk,
    input wire       i_rst_n,
    input wire       i_clk_en,
    input wire       i_clear_n,
    input wire       i_push_enable_a_n,
    input wire       i_pop_enable_a_n,
    input wire       i_pop_enable_b_n,
    input wire       i_output_enable_n,
    input wire [8:0] o_pop_data_out,
    input wire       o_pop_data_out_en_n,
    input wire       o_empty_n,
    input wire       o_almost_empty_n,
    input wire       o_almost_full_n,
    input wire       o_full_n,
    input wire       o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire pop_ok = i_clk_en & i_clear_n & !i_pop_enable_a_n & !i_pop_enable_b_n & o_empty_n;
    data_hold_a: assert property (!pop_ok |=> $stable(o_pop_data_out))
        else $error("pop data changed without an accepted pop");
    empty_hold_a: assert property (!o_empty_n |=> $stable(o_pop_data_out))
        else $error("pop data changed while empty");
    oe_follow_a: assert property (i_clk_en && i_rst_n |=>
        o_pop_data_out_en_n == $past(i_output_enable_n))
        else $error("output enable not followed");
    flag_excl_a: assert property (!(!o_full_n && !o_empty_n))
        else $error("full and empty together");
    aempty_cov_a: assert property (!o_empty_n |-> !o_almost_empty_n)
        else $error("empty without almost-empty");
    afull_cov_a: assert property (!o_full_n |-> !o_almost_full_n)
        else $error("full without almost-full");
    clear_flags_a: assert property (i_clk_en && !i_clear_n |=>
        !o_empty_n && !o_almost_empty_n && o_full_n && o_almost_full_n)
        else $error("flags wrong after clear");
    empty_rise_a: assert property ($rose(o_empty_n) |-> $past(!i_push_enable_a_n))
        else $error("empty flag rose without a push");
    pop_seen_c: cover property (pop_ok);
    full_seen_c: cover property (!o_full_n);
    irq_seen_c: cover property (o_irq);
endmodule // fifo_rp_sva
bind fifo_read_port fifo_rp_sva chk_u (.*);

// ### bench/tb.sv
// Bench for the FIFO read port: fill, drain, modes, output enable, registers.
// Assumes fifo_read_port and its register header on the include path.
`timescale 1ns/1ps
`include "fifo_read_port_regs.vh"
module tb;
    logic clk = 0, rst_n = 0, clr_n = 1, b_pin = 1, oe_n = 0;
    logic go_push = 0, go_pop = 0, one_en = 0;
    logic [8:0] word = 9'h000;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, d;
    logic awvalid = 0, wvalid = 0, arvalid = 0;
    logic [1:0] r;
    wire push_a_n, pop_a_n, pop_b_n, awready, wready, bvalid, arready, rvalid;
    wire en_n, e_n, ae_n, af_n, f_n, irq;
    wire [8:0] pdata, q;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int n_mismatch = 0, n_compared = 0, i;
    always #10 clk = ~clk;
    fifo_peer peer_u (.i_clk(clk), .i_go_push(go_push), .i_go_pop(go_pop), .i_one_en(one_en),
        .i_word(word), .o_push_a_n(push_a_n), .o_pop_a_n(pop_a_n), .o_pop_b_n(pop_b_n),
        .o_data(pdata));
    fifo_read_port dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_clear_n(clr_n),
        .i_push_data_in(pdata), .i_push_enable_a_n(push_a_n),
        .i_push_enable_b_or_offset_load(b_pin), .i_pop_enable_a_n(pop_a_n),
        .i_pop_enable_b_n(pop_b_n), .i_output_enable_n(oe_n), .o_pop_data_out(q),
        .o_pop_data_out_en_n(en_n), .o_empty_n(e_n), .o_almost_empty_n(ae_n),
        .o_almost_full_n(af_n), .o_full_n(f_n), .o_irq(irq), .i_s_axi_awaddr(awaddr),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(1'b1),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(1'b1));
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cyc(input logic p, input logic o, input logic [8:0] w);
        go_push <= p;
        go_pop <= o;
        word <= w;
        @(posedge clk);
        #1;
    endtask
    // Ready is sampled one step after an edge; it holds until the next edge
    task wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er);
        int k;
        logic pa, pw, ta, tw, done;
        pa = 1;
        pw = 1;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        for (k = 0; k < 40; k++)
        begin
            ta = pa & awready;
            tw = pw & wready;
            done = bvalid;
            r = bresp;
            @(posedge clk);
            #1;
            if (ta) begin awvalid <= 0; pa = 0; end
            if (tw) begin wvalid <= 0; pw = 0; end
            if (done) break;
        end
        if (k == 40) begin n_mismatch++; end_sim; end
        else chk(r, er);
    endtask
    task rd(input logic [4:0] a);
        int k;
        logic pa, ta, done;
        pa = 1;
        araddr <= a;
        arvalid <= 1;
        for (k = 0; k < 40; k++)
        begin
            ta = pa & arready;
            done = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            #1;
            if (ta) begin arvalid <= 0; pa = 0; end
            if (done) break;
        end
        if (k == 40) begin n_mismatch++; end_sim; end
    endtask
    task clr(input logic b);
        clr_n <= 0;
        b_pin <= b;
        cyc(0, 0, 9'h000);
        clr_n <= 1;
        cyc(0, 0, 9'h000);
        rd(`REG_STATUS_ADDR);
        chk(d[16], b);
        chk({e_n, ae_n, af_n, f_n}, 4'h3);
        rd(`REG_EMPTY_OFF_ADDR);
        chk(d, 32'h7);
    endtask
    task s_fill;
        wr(`REG_IRQ_MASK_ADDR, 32'hF, `AXI_RESP_OKAY);
        for (i = 1; i <= 256; i++)
        begin
            cyc(1, 0, i[8:0] ^ 9'h1A5);
            chk({e_n, ae_n, af_n, f_n}, {1'b1, i > 7, 256 - i > 7, i < 256});
        end
        cyc(1, 0, 9'h000);
        go_push <= 0;
        rd(`REG_STATUS_ADDR);
        chk(d[8:0], 9'h100);
        chk(irq, 1'b1);
        rd(`REG_IRQ_STATUS_ADDR);
        chk(d[3:0], 4'hC);
        cyc(0, 0, 9'h000);
        chk(irq, 1'b0);
    endtask
    task s_drain;
        one_en <= 1;
        cyc(0, 1, 9'h000);
        chk({f_n, q}, 10'h000);
        one_en <= 0;
        for (i = 1; i <= 256; i++)
        begin
            cyc(0, 1, 9'h000);
            chk(q, i[8:0] ^ 9'h1A5);
            chk({e_n, ae_n, af_n, f_n}, {i < 256, 256 - i > 7, i > 7, 1'b1});
        end
        cyc(0, 1, 9'h000);
        chk(q, 9'h0A5);
        oe_n <= 1;
        cyc(0, 0, 9'h000);
        chk(en_n, 1'b1);
        oe_n <= 0;
        cyc(0, 0, 9'h000);
        chk(en_n, 1'b0);
    endtask
    task s_regs;
        rd(`REG_EMPTY_OFF_ADDR);
        chk(d, 32'h7);
        rd(`REG_FULL_OFF_ADDR);
        chk(d, 32'h7);
        rd(5'h14);
        chk(r, `AXI_RESP_SLVERR);
        wr(5'h14, 32'h1, `AXI_RESP_SLVERR);
        wr(`REG_EMPTY_OFF_ADDR, 32'h2, `AXI_RESP_OKAY);
        cyc(1, 0, 9'h011);
        cyc(1, 0, 9'h022);
        chk(ae_n, 1'b0);
        cyc(1, 0, 9'h033);
        go_push <= 0;
        chk(ae_n, 1'b1);
    endtask
    task s_mode;
        clr(0);
        b_pin <= 0;
        cyc(1, 0, 9'h044);
        go_push <= 0;
        chk(e_n, 1'b1);
        clr(1);
        b_pin <= 0;
        cyc(1, 0, 9'h055);
        go_push <= 0;
        chk(e_n, 1'b0);
        b_pin <= 1;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1;
        cyc(0, 0, 9'h000);
        cyc(0, 0, 9'h000);
        chk({e_n, ae_n, af_n, f_n, irq}, 5'h06);
        s_regs;
        clr(1);
        s_fill;
        s_drain;
        s_mode;
        end_sim;
    end
endmodule // tb

// ### src/fifo_read_port.v
// 256 x 9 FIFO with active-low status flags, strap-selected write enable mode,
// AXI4-Lite registers for the almost offsets, status and interrupts.
// Assumes write and read ports share i_clk; all pins but the async i_rst_n synchronous to it.
//
// Overview of operation
// - Each popped word is presented on a nine-bit data output bus.
// - Both read enables low at a clock edge pops and outputs the next word.
// - While empty flag is low, read requests leave pointer and output unchanged.
// - Output enable registered to the enable output; data bus is never high impedance.
// - Empty flag low when no words are stored, updated on the read clock.
// - Almost-empty low when count at or below empty offset; offset resets to seven.
// - Almost-full low when free space at or below full offset; resets to seven.
// - Full flag low when every location is used; further writes are blocked.
// - Clear returns pointers to start, full flags high, empty flags low.
// - Shared pin sampled at clear: high gives dual enables, low offset load mode.
`timescale 1ns/1ps
`include "fifo_read_port_regs.vh"

module fifo_read_port (
    input  wire                    i_clk,
    input  wire                    i_rst_n,
    input  wire                    i_clk_en,
    input  wire                    i_clear_n,
    input  wire [8:0]              i_push_data_in,
    input  wire                    i_push_enable_a_n,
    input  wire                    i_push_enable_b_or_offset_load,
    input  wire                    i_pop_enable_a_n,
    input  wire                    i_pop_enable_b_n,
    input  wire                    i_output_enable_n,
    output reg  [8:0]              o_pop_data_out,
    output reg                     o_pop_data_out_en_n,
    output reg                     o_empty_n,
    output reg                     o_almost_empty_n,
    output reg                     o_almost_full_n,
    output reg                     o_full_n,
    output reg                     o_irq,
    input  wire [4:0]              i_s_axi_awaddr,
    input  wire                    i_s_axi_awvalid,
    output reg                     o_s_axi_awready,
    input  wire [31:0]             i_s_axi_wdata,
    input  wire [3:0]              i_s_axi_wstrb,
    input  wire                    i_s_axi_wvalid,
    output reg                     o_s_axi_wready,
    output reg  [1:0]              o_s_axi_bresp,
    output reg                     o_s_axi_bvalid,
    input  wire                    i_s_axi_bready,
    input  wire [4:0]              i_s_axi_araddr,
    input  wire                    i_s_axi_arvalid,
    output reg                     o_s_axi_arready,
    output reg  [31:0]             o_s_axi_rdata,
    output reg  [1:0]              o_s_axi_rresp,
    output reg                     o_s_axi_rvalid,
    input  wire                    i_s_axi_rready
);

    reg [`FIFO_DATA_W-1:0] mem [0:`FIFO_DEPTH-1];

    reg [`FIFO_ADDR_W-1:0] wr_ptr_q;
    reg [`FIFO_ADDR_W-1:0] rd_ptr_q;
    reg [`FIFO_CNT_W-1:0]  cnt_q;
    reg [`FIFO_CNT_W-1:0]  cnt_d;
    reg                    dual_mode_q;
    reg                    strap_pending_q;
    reg [7:0]              empty_off_q;
    reg [7:0]              full_off_q;
    reg [3:0]              irq_status_q;
    reg [3:0]              irq_mask_q;

    reg                    aw_held_q;
    reg [4:0]              aw_addr_q;
    reg                    w_held_q;
    reg [31:0]             w_data_q;
    reg [3:0]              w_strb_q;

    wire                   push_req;
    wire                   push_ok;
    wire                   pop_ok;
    wire                   next_empty_n;
    wire                   next_aempty_n;
    wire                   next_afull_n;
    wire                   next_full_n;
    wire [`FIFO_CNT_W-1:0] free_d;
    wire [3:0]             irq_event;
    wire                   wr_fire;
    wire                   rd_fire;
    wire                   clr_irq_rd;
    wire                   off_wr_empty;
    wire                   off_wr_full;
    reg  [31:0]            rd_mux;
    reg                    rd_hit;

    // In offset load mode the shared pin is not a write enable
    assign push_req = !i_push_enable_a_n &&
                      (!dual_mode_q || i_push_enable_b_or_offset_load);
    assign push_ok  = i_clear_n && !strap_pending_q && push_req && o_full_n;
    assign pop_ok   = i_clear_n && !i_pop_enable_a_n && !i_pop_enable_b_n
                      && o_empty_n;

    // One clock, so a single count register serves both sides
    always @*
    begin
        cnt_d = cnt_q;
        if (push_ok && !pop_ok)
            cnt_d = cnt_q + 9'h001;
        else if (pop_ok && !push_ok)
            cnt_d = cnt_q - 9'h001;
    end

    assign free_d        = `FIFO_DEPTH - cnt_d;
    assign next_empty_n  = (cnt_d != 9'h000);
    assign next_aempty_n = (cnt_d > {1'b0, empty_off_q});
    assign next_afull_n  = (free_d > {1'b0, full_off_q});
    assign next_full_n   = (cnt_d != `FIFO_DEPTH);

    // Events fire on the edge where a flag enters its active-low state
    assign irq_event = {o_full_n & ~next_full_n,
                        o_almost_full_n & ~next_afull_n,
                        o_almost_empty_n & ~next_aempty_n,
                        o_empty_n & ~next_empty_n};

    // Stored words survive a clear; the pointers, count, flags and offsets restart
    always @(posedge i_clk)
    begin
        if (i_clk_en && push_ok)
            mem[wr_ptr_q] <= i_push_data_in;
    end

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr_q         <= 8'h00;
            rd_ptr_q         <= 8'h00;
            cnt_q            <= 9'h000;
            o_pop_data_out   <= 9'h000;
            o_empty_n        <= 1'b0;
            o_almost_empty_n <= 1'b0;
            o_almost_full_n  <= 1'b1;
            o_full_n         <= 1'b1;
            dual_mode_q      <= 1'b0;
            strap_pending_q  <= 1'b1;
        end
        else if (i_clk_en)
        begin
            if (!i_clear_n || strap_pending_q)
            begin
                // Strap is captured by the clock, never by the async reset
                // Flags are forced directly so that a clear raises no event
                dual_mode_q      <= i_push_enable_b_or_offset_load;
                strap_pending_q  <= 1'b0;
                wr_ptr_q         <= 8'h00;
                rd_ptr_q         <= 8'h00;
                cnt_q            <= 9'h000;
                o_empty_n        <= 1'b0;
                o_almost_empty_n <= 1'b0;
                o_almost_full_n  <= 1'b1;
                o_full_n         <= 1'b1;
            end
            else
            begin
                if (push_ok)
                    wr_ptr_q <= wr_ptr_q + 8'h01;
                if (pop_ok)
                begin
                    o_pop_data_out <= mem[rd_ptr_q];
                    rd_ptr_q       <= rd_ptr_q + 8'h01;
                end
                cnt_q            <= cnt_d;
                o_empty_n        <= next_empty_n;
                o_almost_empty_n <= next_aempty_n;
                o_almost_full_n  <= next_afull_n;
                o_full_n         <= next_full_n;
            end
        end
    end

    // Enable is registered so the output pin pair comes from flip-flops
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_pop_data_out_en_n <= 1'b1;
        else if (i_clk_en)
            o_pop_data_out_en_n <= i_output_enable_n;
    end

    // AXI4-Lite write side: address and data held separately, either order
    assign wr_fire = aw_held_q && w_held_q && !o_s_axi_bvalid;

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            aw_held_q       <= 1'b0;
            aw_addr_q       <= 5'h00;
            w_held_q        <= 1'b0;
            w_data_q        <= 32'h00000000;
            w_strb_q        <= 4'h0;
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready  <= 1'b0;
            o_s_axi_bvalid  <= 1'b0;
            o_s_axi_bresp   <= `AXI_RESP_OKAY;
            irq_mask_q      <= `IRQ_MASK_RESET;
        end
        else if (i_clk_en)
        begin
            o_s_axi_awready <= !aw_held_q && !o_s_axi_awready;
            o_s_axi_wready  <= !w_held_q && !o_s_axi_wready;
            if (o_s_axi_awready && i_s_axi_awvalid)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= i_s_axi_awaddr;
            end
            if (o_s_axi_wready && i_s_axi_wvalid)
            begin
                w_held_q <= 1'b1;
                w_data_q <= i_s_axi_wdata;
                w_strb_q <= i_s_axi_wstrb;
            end
            if (o_s_axi_bvalid && i_s_axi_bready)
                o_s_axi_bvalid <= 1'b0;
            if (wr_fire)
            begin
                aw_held_q      <= 1'b0;
                w_held_q       <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= `AXI_RESP_OKAY;
                case (aw_addr_q)
                    {1'b0, `REG_EMPTY_OFF_ADDR}, {1'b0, `REG_FULL_OFF_ADDR}:
                        o_s_axi_bresp <= `AXI_RESP_OKAY;
                    `REG_IRQ_MASK_ADDR:
                        if (w_strb_q[0])
                            irq_mask_q <= w_data_q[3:0];
                    {1'b0, `REG_STATUS_ADDR}, {1'b0, `REG_IRQ_STATUS_ADDR}:
                        o_s_axi_bresp <= `AXI_RESP_OKAY;
                    default:
                        o_s_axi_bresp <= `AXI_RESP_SLVERR;
                endcase
            end
        end
    end

    // Offsets are kept apart from the bus logic so that a FIFO clear
    // reloads them; the clear wins over a bus write in the same cycle
    assign off_wr_empty = wr_fire && w_strb_q[0] &&
                          (aw_addr_q == {1'b0, `REG_EMPTY_OFF_ADDR});
    assign off_wr_full  = wr_fire && w_strb_q[0] &&
                          (aw_addr_q == {1'b0, `REG_FULL_OFF_ADDR});

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            empty_off_q <= `OFFSET_RESET;
            full_off_q  <= `OFFSET_RESET;
        end
        else if (i_clk_en)
        begin
            if (!i_clear_n)
            begin
                empty_off_q <= `OFFSET_RESET;
                full_off_q  <= `OFFSET_RESET;
            end
            else
            begin
                if (off_wr_empty)
                    empty_off_q <= w_data_q[7:0];
                if (off_wr_full)
                    full_off_q <= w_data_q[7:0];
            end
        end
    end

    // AXI4-Lite read side
    // Read data is a snapshot taken at the address handshake
    assign rd_fire    = o_s_axi_arready && i_s_axi_arvalid;
    assign clr_irq_rd = rd_fire && (i_s_axi_araddr == {1'b0, `REG_IRQ_STATUS_ADDR});

    always @*
    begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (i_s_axi_araddr)
            {1'b0, `REG_STATUS_ADDR}:
            begin
                rd_mux[`STAT_CNT_LSB +: `FIFO_CNT_W] = cnt_q;
                rd_mux[`STAT_EMPTY_BIT]  = o_empty_n;
                rd_mux[`STAT_AEMPTY_BIT] = o_almost_empty_n;
                rd_mux[`STAT_AFULL_BIT]  = o_almost_full_n;
                rd_mux[`STAT_FULL_BIT]   = o_full_n;
                rd_mux[`STAT_MODE_BIT]   = dual_mode_q;
            end
            {1'b0, `REG_EMPTY_OFF_ADDR}:  rd_mux[7:0] = empty_off_q;
            {1'b0, `REG_FULL_OFF_ADDR}:   rd_mux[7:0] = full_off_q;
            {1'b0, `REG_IRQ_STATUS_ADDR}: rd_mux[3:0] = irq_status_q;
            `REG_IRQ_MASK_ADDR:           rd_mux[3:0] = irq_mask_q;
            default:                      rd_hit = 1'b0;
        endcase
    end

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid  <= 1'b0;
            o_s_axi_rdata   <= 32'h00000000;
            o_s_axi_rresp   <= `AXI_RESP_OKAY;
        end
        else if (i_clk_en)
        begin
            o_s_axi_arready <= !o_s_axi_rvalid && !o_s_axi_arready;
            if (rd_fire)
            begin
                o_s_axi_arready <= 1'b0;
                o_s_axi_rvalid  <= 1'b1;
                o_s_axi_rdata   <= rd_mux;
                o_s_axi_rresp   <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end
            else if (o_s_axi_rvalid && i_s_axi_rready)
                o_s_axi_rvalid <= 1'b0;
        end
    end

    // Read clears the sticky bits, but an event in the same cycle survives
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            irq_status_q <= 4'h0;
            o_irq        <= 1'b0;
        end
        else if (i_clk_en)
        begin
            irq_status_q <= (clr_irq_rd ? 4'h0 : irq_status_q) |
                            ((i_clear_n && !strap_pending_q) ? irq_event : 4'h0);
            o_irq        <= |(irq_status_q & irq_mask_q);
        end
    end

endmodule // fifo_read_port

// ### src/fifo_read_port_regs.vh
// Constants for the 256 x 9 FIFO: depth, widths, register map, reset values.
// Included by the FIFO top module; holds definitions only.
`ifndef FIFO_READ_PORT_REGS_VH
`define FIFO_READ_PORT_REGS_VH

`define FIFO_DATA_W          9
`define FIFO_ADDR_W          8
`define FIFO_CNT_W           9
`define FIFO_DEPTH           9'h100

`define REG_STATUS_ADDR      4'h0
`define REG_EMPTY_OFF_ADDR   4'h4
`define REG_FULL_OFF_ADDR    4'h8
`define REG_IRQ_STATUS_ADDR  4'hC
`define REG_IRQ_MASK_ADDR    5'h10

`define OFFSET_RESET         8'h07
`define IRQ_MASK_RESET       4'h0

`define STAT_CNT_LSB         0
`define STAT_EMPTY_BIT       12
`define STAT_AEMPTY_BIT      13
`define STAT_AFULL_BIT       14
`define STAT_FULL_BIT        15
`define STAT_MODE_BIT        16

`define IRQ_EMPTY_BIT        0
`define IRQ_AEMPTY_BIT       1
`define IRQ_AFULL_BIT        2
`define IRQ_FULL_BIT         3

`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2

`endif
